// File: rtl/bsu_cond_sel.sv
/*
 * Branch condition selector: picks one status flag, or the signed
 * combination, and compares it with the wanted level.
 * Assumes the status register is stable in the issue cycle.
 */
`timescale 1ns/1ps
`include "bsu_regs.svh"
module bsu_cond_sel (
	// Status and selection
	input  wire logic [7:0] status_flags_register_i,
	input  wire logic [2:0] flag_sel_i,
	input  wire logic       signed_i,
	input  wire logic       want_one_i,
	// Result
	output logic            taken_o
);
	logic flag;

	// Z, C, N, H, T, V, I branches are all an index into the flags
	always_comb begin
		if (signed_i)
			flag = status_flags_register_i[`BSU_FLAG_N] ^ status_flags_register_i[`BSU_FLAG_V];
		else
			flag = status_flags_register_i[flag_sel_i];
		taken_o = (flag == want_one_i);
	end
endmodule // bsu_cond_sel

// File: rtl/bsu_exec_unit.sv
/*
 * Execution unit for skips, flag branches, I/O bit forcing, shifts and
 * spare-bit moves. Holds the program counter and the status flags.
 * Assumes the core fetches operands before issue, writes rd_data_o back
 * to the issued destination register and io_data_o to io_addr_o, and
 * issues only while busy_o is low.
 */
`timescale 1ns/1ps
`include "bsu_regs.svh"
module bsu_exec_unit
	import bsu_pkg::*;
(
	// Clock and reset
	input  wire logic                ref_clk_i,
	input  wire logic                srst_i,
	// Instruction issue
	input  wire bsu_pkg::bsu_issue_t issue_i,
	// Flag load from the rest of the core
	input  wire logic                status_flags_register_we_i,
	input  wire logic [7:0]          status_flags_register_wdata_i,
	// Program flow
	output logic [15:0]              pc_o,
	output logic                     busy_o,
	// Status flags
	output logic [7:0]               status_flags_register_o,
	// Register write back
	output logic                     rd_we_o,
	output logic [7:0]               rd_data_o,
	// I/O write
	output logic                     io_we_o,
	output logic [5:0]               io_addr_o,
	output logic [7:0]               io_data_o
);
	bsu_state_t st;
	bsu_state_t next_st;

	logic       accept;
	logic       reg_bit;
	logic       io_bit;
	logic       br_taken;
	logic [7:0] sh_res;
	logic       sh_c;
	logic       sh_z;
	logic       sh_n;
	logic       sh_v;

	// One-hot mask of a selected bit, shared by I/O forcing and bit load
	function automatic logic [7:0] bit_mask(input logic [2:0] sel);
		bit_mask = 8'h01 << sel;
	endfunction

	// Sign-extended word displacement of a relative branch
	function automatic logic [15:0] rel_off(input logic [6:0] k);
		rel_off = {{9{k[6]}}, k};
	endfunction

	// Issue is taken only when nothing is in flight
	assign accept  = issue_i.valid && !st.busy;
	assign reg_bit = issue_i.reg_val[issue_i.bit_sel];
	assign io_bit  = issue_i.io_val[issue_i.bit_sel];

	// Flag condition for all relative branches
	bsu_cond_sel u_cond (
		.status_flags_register_i     (st.status_flags_register),
		.flag_sel_i (issue_i.bit_sel),
		.signed_i   ((issue_i.op == BSU_OP_BR_SIGN_GE) || (issue_i.op == BSU_OP_BR_SIGN_LT)),
		.want_one_i ((issue_i.op == BSU_OP_BR_FLAG_HI) || (issue_i.op == BSU_OP_BR_SIGN_LT)),
		.taken_o    (br_taken)
	);

	// Shift datapath, carry taken from the live flags
	bsu_shift_unit u_shift (
		.op_i    (issue_i.op),
		.val_i   (issue_i.reg_val),
		.carry_i (st.status_flags_register[`BSU_FLAG_C]),
		.res_o   (sh_res),
		.c_o     (sh_c),
		.z_o     (sh_z),
		.n_o     (sh_n),
		.v_o     (sh_v)
	);

	// Next-state logic; write strobes last one cycle
	always_comb begin
		next_st       = st;
		next_st.rd_we = 1'b0;
		next_st.io_we = 1'b0;
		if (status_flags_register_we_i)
			next_st.status_flags_register = status_flags_register_wdata_i;
		if (st.busy) begin
			// Wait out the extra cycles of a multi-cycle op
			next_st.busy_cnt = st.busy_cnt - 2'h1;
			next_st.busy     = (st.busy_cnt != `BSU_EXTRA_ONE);
		end else if (accept) begin
			next_st.pc = st.pc + 16'h0001;
			case (issue_i.op)
				BSU_OP_SKIP_REG_LO,
				BSU_OP_SKIP_REG_HI,
				BSU_OP_SKIP_IO_LO,
				BSU_OP_SKIP_IO_HI: begin
					// Skip length follows the size of the next word
					if (((issue_i.op == BSU_OP_SKIP_REG_LO) && !reg_bit) ||
					    ((issue_i.op == BSU_OP_SKIP_REG_HI) && reg_bit) ||
					    ((issue_i.op == BSU_OP_SKIP_IO_LO) && !io_bit) ||
					    ((issue_i.op == BSU_OP_SKIP_IO_HI) && io_bit)) begin
						if (issue_i.next_two_word) begin
							next_st.pc       = st.pc + 16'h0003;
							next_st.busy_cnt = `BSU_EXTRA_TWO;
						end else begin
							next_st.pc       = st.pc + 16'h0002;
							next_st.busy_cnt = `BSU_EXTRA_ONE;
						end
						next_st.busy = 1'b1;
					end
				end
				BSU_OP_BR_FLAG_HI,
				BSU_OP_BR_FLAG_LO,
				BSU_OP_BR_SIGN_GE,
				BSU_OP_BR_SIGN_LT: begin
					// Taken branch costs one extra cycle for the refetch
					if (br_taken) begin
						next_st.pc       = st.pc + rel_off(issue_i.k) + 16'h0001;
						next_st.busy_cnt = `BSU_EXTRA_ONE;
						next_st.busy     = 1'b1;
					end
				end
				BSU_OP_IO_ONE,
				BSU_OP_IO_ZERO: begin
					// Read-modify-write of the whole I/O byte
					next_st.io_we   = 1'b1;
					next_st.io_addr = issue_i.io_addr;
					if (issue_i.op == BSU_OP_IO_ONE)
						next_st.io_data = issue_i.io_val | bit_mask(issue_i.bit_sel);
					else
						next_st.io_data = issue_i.io_val & ~bit_mask(issue_i.bit_sel);
					next_st.busy_cnt = `BSU_EXTRA_ONE;
					next_st.busy     = 1'b1;
				end
				BSU_OP_ROT_UP,
				BSU_OP_ROT_DOWN,
				BSU_OP_SHR_SIGNED,
				BSU_OP_SHL_LOGIC,
				BSU_OP_SHR_LOGIC: begin
					next_st.rd_we              = 1'b1;
					next_st.rd_data            = sh_res;
					next_st.status_flags_register[`BSU_FLAG_C]  = sh_c;
					next_st.status_flags_register[`BSU_FLAG_Z]  = sh_z;
					next_st.status_flags_register[`BSU_FLAG_N]  = sh_n;
					next_st.status_flags_register[`BSU_FLAG_V]  = sh_v;
				end
				BSU_OP_BIT_TO_T: begin
					next_st.status_flags_register[`BSU_FLAG_T] = reg_bit;
				end
				BSU_OP_T_TO_BIT: begin
					// Flags untouched; only the chosen bit changes
					next_st.rd_we = 1'b1;
					if (st.status_flags_register[`BSU_FLAG_T])
						next_st.rd_data = issue_i.reg_val | bit_mask(issue_i.bit_sel);
					else
						next_st.rd_data = issue_i.reg_val & ~bit_mask(issue_i.bit_sel);
				end
				default: begin
					next_st.pc = st.pc + 16'h0001;
				end
			endcase
		end
	end

	// State register; reset loads constants only
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			st          <= '0;
			st.pc       <= `BSU_PC_RST;
			st.status_flags_register     <= `BSU_STATUS_FLAGS_REGISTER_RST;
			st.busy_cnt <= `BSU_EXTRA_NONE;
		end else begin
			st <= next_st;
		end
	end

	// Outputs straight from the state flops
	assign pc_o      = st.pc;
	assign busy_o    = st.busy;
	assign status_flags_register_o    = st.status_flags_register;
	assign rd_we_o   = st.rd_we;
	assign rd_data_o = st.rd_data;
	assign io_we_o   = st.io_we;
	assign io_addr_o = st.io_addr;
	assign io_data_o = st.io_data;

	// Checks on the unit's own outputs
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (srst_i);

	// Two and three cycle occupancy shapes
	sequence busy_one_s;
		busy_o ##1 !busy_o;
	endsequence
	sequence busy_two_s;
		busy_o [*2] ##1 !busy_o;
	endsequence

	skip_one_word_a: assert property (
		accept && (issue_i.op == BSU_OP_SKIP_REG_LO) && !reg_bit && !issue_i.next_two_word
		|=> (pc_o == $past(pc_o) + 16'h0002) and busy_one_s)
		else $error("skip over one word wrong");

	skip_two_word_a: assert property (
		accept && (issue_i.op == BSU_OP_SKIP_REG_HI) && reg_bit && issue_i.next_two_word
		|=> (pc_o == $past(pc_o) + 16'h0003) and busy_two_s)
		else $error("skip over two words wrong");

	skip_io_none_a: assert property (
		accept && (issue_i.op == BSU_OP_SKIP_IO_LO) && io_bit
		|=> (pc_o == $past(pc_o) + 16'h0001) && !busy_o)
		else $error("skip fired on wrong io level");

	skip_io_hit_a: assert property (
		accept && (issue_i.op == BSU_OP_SKIP_IO_HI) && io_bit && !issue_i.next_two_word
		|=> pc_o == $past(pc_o) + 16'h0002)
		else $error("io skip did not skip");

	branch_taken_a: assert property (
		accept && (issue_i.op == BSU_OP_BR_FLAG_HI) && status_flags_register_o[issue_i.bit_sel]
		|=> (pc_o == $past(pc_o) + rel_off($past(issue_i.k)) + 16'h0001) and busy_one_s)
		else $error("taken branch target or timing wrong");

	branch_not_a: assert property (
		accept && (issue_i.op == BSU_OP_BR_FLAG_LO) && status_flags_register_o[issue_i.bit_sel]
		|=> (pc_o == $past(pc_o) + 16'h0001) && !busy_o)
		else $error("untaken branch moved too far");

	branch_signed_a: assert property (
		accept && (issue_i.op == BSU_OP_BR_SIGN_LT) && (status_flags_register_o[`BSU_FLAG_N] == status_flags_register_o[`BSU_FLAG_V])
		|=> pc_o == $past(pc_o) + 16'h0001)
		else $error("signed branch taken on equal sign");

	flow_flags_a: assert property (
		accept && !status_flags_register_we_i && (issue_i.op inside {[BSU_OP_SKIP_REG_LO:BSU_OP_IO_ZERO]})
		|=> $stable(status_flags_register_o))
		else $error("flow op changed flags");

	io_force_a: assert property (
		accept && (issue_i.op == BSU_OP_IO_ONE)
		|=> (io_we_o && io_data_o[$past(issue_i.bit_sel)]) and busy_one_s)
		else $error("io bit not forced high");

	io_clear_a: assert property (
		accept && (issue_i.op == BSU_OP_IO_ZERO)
		|=> io_we_o && !io_data_o[$past(issue_i.bit_sel)] && (io_addr_o == $past(issue_i.io_addr)))
		else $error("io bit not forced low");

	rot_up_a: assert property (
		accept && !status_flags_register_we_i && (issue_i.op == BSU_OP_ROT_UP)
		|=> rd_we_o && (rd_data_o[0] == $past(status_flags_register_o[`BSU_FLAG_C]))
		&& (status_flags_register_o[`BSU_FLAG_C] == $past(issue_i.reg_val[7])) && !busy_o)
		else $error("rotate up through carry wrong");

	shr_sign_a: assert property (
		accept && !status_flags_register_we_i && (issue_i.op == BSU_OP_SHR_SIGNED)
		|=> (rd_data_o[7:6] == {2{$past(issue_i.reg_val[7])}})
		&& (status_flags_register_o[`BSU_FLAG_C] == $past(issue_i.reg_val[0])))
		else $error("signed shift lost sign or carry");

	bit_store_a: assert property (
		accept && !status_flags_register_we_i && (issue_i.op == BSU_OP_BIT_TO_T)
		|=> status_flags_register_o[`BSU_FLAG_T] == $past(reg_bit))
		else $error("spare bit store wrong");

	bit_load_a: assert property (
		accept && !status_flags_register_we_i && (issue_i.op == BSU_OP_T_TO_BIT)
		|=> rd_we_o && (rd_data_o[$past(issue_i.bit_sel)] == status_flags_register_o[`BSU_FLAG_T]) && $stable(status_flags_register_o))
		else $error("spare bit load wrong");

	// Misses and the remaining skip shapes
	skip_reg_miss_a: assert property (
		accept && (issue_i.op == BSU_OP_SKIP_REG_LO) && reg_bit
		|=> (pc_o == $past(pc_o) + 16'h0001) && !busy_o)
		else $error("register skip fired on set bit");

	skip_high_miss_a: assert property (
		accept && (issue_i.op == BSU_OP_SKIP_REG_HI) && !reg_bit
		|=> (pc_o == $past(pc_o) + 16'h0001) && !busy_o)
		else $error("register skip fired on clear bit");

	skip_io_two_a: assert property (
		accept && (issue_i.op == BSU_OP_SKIP_IO_LO) && !io_bit && issue_i.next_two_word
		|=> (pc_o == $past(pc_o) + 16'h0003) and busy_two_s)
		else $error("io skip over two words wrong");

	skip_io_miss_a: assert property (
		accept && (issue_i.op == BSU_OP_SKIP_IO_HI) && !io_bit
		|=> (pc_o == $past(pc_o) + 16'h0001) && !busy_o)
		else $error("io skip fired on clear bit");

	// Both polarities of the flag branches
	branch_low_taken_a: assert property (
		accept && (issue_i.op == BSU_OP_BR_FLAG_LO) && !status_flags_register_o[issue_i.bit_sel]
		|=> (pc_o == $past(pc_o) + rel_off($past(issue_i.k)) + 16'h0001) and busy_one_s)
		else $error("branch on clear flag not taken");

	branch_high_miss_a: assert property (
		accept && (issue_i.op == BSU_OP_BR_FLAG_HI) && !status_flags_register_o[issue_i.bit_sel]
		|=> (pc_o == $past(pc_o) + 16'h0001) && !busy_o)
		else $error("branch on set flag taken wrongly");

	branch_ge_taken_a: assert property (
		accept && (issue_i.op == BSU_OP_BR_SIGN_GE) && (status_flags_register_o[`BSU_FLAG_N] == status_flags_register_o[`BSU_FLAG_V])
		|=> (pc_o == $past(pc_o) + rel_off($past(issue_i.k)) + 16'h0001) and busy_one_s)
		else $error("signed ge branch not taken");

	branch_lt_taken_a: assert property (
		accept && (issue_i.op == BSU_OP_BR_SIGN_LT) && (status_flags_register_o[`BSU_FLAG_N] != status_flags_register_o[`BSU_FLAG_V])
		|=> (pc_o == $past(pc_o) + rel_off($past(issue_i.k)) + 16'h0001) and busy_one_s)
		else $error("signed lt branch not taken");

	// An issue offered while busy must leave no trace
	busy_hold_a: assert property (
		busy_o && !status_flags_register_we_i
		|=> $stable(pc_o) && $stable(status_flags_register_o) && !rd_we_o && !io_we_o)
		else $error("busy cycle changed state");

	io_keep_a: assert property (
		accept && ((issue_i.op == BSU_OP_IO_ONE) || (issue_i.op == BSU_OP_IO_ZERO))
		|=> ((io_data_o | bit_mask($past(issue_i.bit_sel)))
		== ($past(issue_i.io_val) | bit_mask($past(issue_i.bit_sel)))))
		else $error("io write disturbed other bits");

	io_pulse_a: assert property (
		io_we_o
		|=> !io_we_o)
		else $error("io write strobe too long");

	rot_down_a: assert property (
		accept && !status_flags_register_we_i && (issue_i.op == BSU_OP_ROT_DOWN)
		|=> rd_we_o && (rd_data_o == {$past(status_flags_register_o[`BSU_FLAG_C]), $past(issue_i.reg_val[7:1])})
		&& (status_flags_register_o[`BSU_FLAG_C] == $past(issue_i.reg_val[0])) && !busy_o)
		else $error("rotate down through carry wrong");

	shift_flags_a: assert property (
		accept && !status_flags_register_we_i && (issue_i.op == BSU_OP_SHR_SIGNED)
		|=> rd_we_o && (rd_data_o[6:0] == $past(issue_i.reg_val[7:1]))
		&& (status_flags_register_o[`BSU_FLAG_Z] == (rd_data_o == 8'h00)) && (status_flags_register_o[`BSU_FLAG_N] == rd_data_o[7])
		&& (status_flags_register_o[`BSU_FLAG_V] == (rd_data_o[7] ^ status_flags_register_o[`BSU_FLAG_C]))
		&& (status_flags_register_o[7:4] == $past(status_flags_register_o[7:4])) && !busy_o)
		else $error("signed shift flags wrong");

	bit_load_keep_a: assert property (
		accept && (issue_i.op == BSU_OP_T_TO_BIT)
		|=> ((rd_data_o | bit_mask($past(issue_i.bit_sel)))
		== ($past(issue_i.reg_val) | bit_mask($past(issue_i.bit_sel)))))
		else $error("bit load disturbed other bits");
endmodule // bsu_exec_unit

// File: rtl/bsu_pkg.sv
/*
 * Types of the branch, skip and bit unit.
 * Assumes bsu_regs.svh is on the include path.
 */
package bsu_pkg;
	`include "bsu_regs.svh"

	// Operations handled by this unit
	typedef enum logic [4:0] {
		BSU_OP_NOP        = 5'h00,
		BSU_OP_SKIP_REG_LO = 5'h01,
		BSU_OP_SKIP_REG_HI = 5'h02,
		BSU_OP_SKIP_IO_LO  = 5'h03,
		BSU_OP_SKIP_IO_HI  = 5'h04,
		BSU_OP_BR_FLAG_HI  = 5'h05,
		BSU_OP_BR_FLAG_LO  = 5'h06,
		BSU_OP_BR_SIGN_GE  = 5'h07,
		BSU_OP_BR_SIGN_LT  = 5'h08,
		BSU_OP_IO_ONE      = 5'h09,
		BSU_OP_IO_ZERO     = 5'h0A,
		BSU_OP_ROT_UP      = 5'h0B,
		BSU_OP_ROT_DOWN    = 5'h0C,
		BSU_OP_SHR_SIGNED  = 5'h0D,
		BSU_OP_SHL_LOGIC   = 5'h0E,
		BSU_OP_SHR_LOGIC   = 5'h0F,
		BSU_OP_BIT_TO_T    = 5'h10,
		BSU_OP_T_TO_BIT    = 5'h11
	} bsu_op_t;

	// One issued instruction with its operands already fetched
	typedef struct packed {
		logic        valid;
		bsu_op_t     op;
		logic [2:0]  bit_sel;
		logic [5:0]  io_addr;
		logic [6:0]  k;
		logic [7:0]  reg_val;
		logic [7:0]  io_val;
		logic        next_two_word;
	} bsu_issue_t;

	// Whole state of the execution unit
	typedef struct packed {
		logic [15:0] pc;
		logic [7:0]  status_flags_register;
		logic [1:0]  busy_cnt;
		logic        busy;
		logic        rd_we;
		logic [7:0]  rd_data;
		logic        io_we;
		logic [5:0]  io_addr;
		logic [7:0]  io_data;
	} bsu_state_t;
endpackage

// File: rtl/bsu_regs.svh
/*
 * Constants of the branch, skip and bit unit: status flag positions,
 * reset values and cycle counts.
 * Assumes inclusion by its bare name from the package and the modules.
 */
`ifndef BSU_REGS_SVH
`define BSU_REGS_SVH


// Status flag positions
`define BSU_FLAG_C 3'h0
`define BSU_FLAG_Z 3'h1
`define BSU_FLAG_N 3'h2
`define BSU_FLAG_V 3'h3
`define BSU_FLAG_S 3'h4
`define BSU_FLAG_H 3'h5
`define BSU_FLAG_T 3'h6
`define BSU_FLAG_I 3'h7

// Reset values
`define BSU_STATUS_FLAGS_REGISTER_RST 8'h00
`define BSU_PC_RST   16'h0000

// Extra busy cycles after the issue cycle
`define BSU_EXTRA_NONE 2'h0
`define BSU_EXTRA_ONE  2'h1
`define BSU_EXTRA_TWO  2'h2

`endif

// File: rtl/bsu_shift_unit.sv
/*
 * Shift and rotate datapath with its flag results.
 * Assumes carry in is the current borrow-out flag.
 */
`timescale 1ns/1ps
module bsu_shift_unit
	import bsu_pkg::*;
(
	// Operand
	input  wire bsu_pkg::bsu_op_t op_i,
	input  wire logic [7:0]       val_i,
	input  wire logic             carry_i,
	// Result and flags
	output logic [7:0]            res_o,
	output logic                  c_o,
	output logic                  z_o,
	output logic                  n_o,
	output logic                  v_o
);
	// Carry out is the bit pushed off the end for every shift op; other ops pass carry in through
	always_comb begin
		case (op_i)
			BSU_OP_ROT_UP: begin
				res_o = {val_i[6:0], carry_i};
				c_o   = val_i[7];
			end
			BSU_OP_ROT_DOWN: begin
				res_o = {carry_i, val_i[7:1]};
				c_o   = val_i[0];
			end
			BSU_OP_SHR_SIGNED: begin
				res_o = {val_i[7], val_i[7:1]};
				c_o   = val_i[0];
			end
			BSU_OP_SHL_LOGIC: begin
				res_o = {val_i[6:0], 1'b0};
				c_o   = val_i[7];
			end
			BSU_OP_SHR_LOGIC: begin
				res_o = {1'b0, val_i[7:1]};
				c_o   = val_i[0];
			end
			default: begin
				res_o = val_i;
				c_o   = carry_i;
			end
		endcase
		z_o = (res_o == 8'h00);
		n_o = res_o[7];
		v_o = res_o[7] ^ c_o;
	end
endmodule // bsu_shift_unit

// File: tb/bsu_far_model.sv
/*
 * Far-side model: one I/O byte space that takes the unit's whole-byte
 * writes and answers reads. Assumes one clock and synchronous reset.
 */
`timescale 1ns/1ps
module bsu_far_model #(
	parameter logic [7:0] INIT = 8'h5A
) (
	// Clock and reset
	input  wire logic       ref_clk_i,
	input  wire logic       srst_i,
	// Writes from the unit
	input  wire logic       io_we_i,
	input  wire logic [5:0] io_addr_i,
	input  wire logic [7:0] io_data_i,
	// Read port
	input  wire logic [5:0] rd_addr_i,
	output logic [7:0]      rd_data_o
);
	logic [7:0] mem [64];

	// Whole bytes land; the unit must merge the forced bit itself
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			for (int i = 0; i < 64; i++) begin
				mem[i] <= INIT;
			end
		end else if (io_we_i) begin
			mem[io_addr_i] <= io_data_i;
		end
	end

	// Reads are combinational, like a register file port
	assign rd_data_o = mem[rd_addr_i];
endmodule // bsu_far_model

// File: tb/tb_top.sv
/*
 * Self-checking bench of the execution unit: skips, flag branches,
 * I/O bit forcing, shifts and spare-bit moves.
 * Assumes the far model holds the I/O byte at address 05.
 */
`timescale 1ns/1ps
module tb_top;
	import bsu_pkg::*;
	logic       ref_clk_i, srst_i, status_flags_register_we_i, busy_o, rd_we_o, io_we_o, tk, hit, c, co;
	logic [7:0] status_flags_register_wdata_i, status_flags_register_o, rd_data_o, io_data_o, io_rd, es, em, s, v, r, e;
	logic [7:0] cap_rd, cap_io, cap_rdwe, cap_iowe;
	logic [5:0] io_addr_o, cap_addr;
	logic [6:0] k;
	logic [15:0] pc_o, epc;
	bsu_issue_t issue_i;
	int         fails, compares, cyc;
	bsu_op_t    sk[4] = '{BSU_OP_SKIP_REG_LO, BSU_OP_SKIP_REG_HI, BSU_OP_SKIP_IO_LO, BSU_OP_SKIP_IO_HI};
	bsu_op_t    sh[5] = '{BSU_OP_ROT_UP, BSU_OP_ROT_DOWN, BSU_OP_SHR_SIGNED, BSU_OP_SHL_LOGIC, BSU_OP_SHR_LOGIC};
	logic [7:0] vals[4] = '{8'h81, 8'h00, 8'h40, 8'h7F};

	bsu_exec_unit bsu_exec_unit_i (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .issue_i(issue_i),
		.status_flags_register_we_i(status_flags_register_we_i), .status_flags_register_wdata_i(status_flags_register_wdata_i), .pc_o(pc_o), .busy_o(busy_o),
		.status_flags_register_o(status_flags_register_o), .rd_we_o(rd_we_o), .rd_data_o(rd_data_o), .io_we_o(io_we_o),
		.io_addr_o(io_addr_o), .io_data_o(io_data_o));
	bsu_far_model #(.INIT(8'h5A)) bsu_far_model_i (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
		.io_we_i(io_we_o), .io_addr_i(io_addr_o), .io_data_i(io_data_o), .rd_addr_i(6'h05),
		.rd_data_o(io_rd));

	// 40 MHz clock
	initial begin
		ref_clk_i = 1'b0;
		forever #12.5 ref_clk_i = ~ref_clk_i;
	end

	// Hang guard, well above the few hundred cycles the tests need
	always @(posedge ref_clk_i) begin
		cyc++;
		if (cyc == 6000) begin
			fails++;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		$display("compares=%0d fails=%0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] sn, input logic [15:0] ex);
		compares++;
		if (sn !== ex) begin
			fails++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, sn, ex);
		end
	endtask

	// Flags come in over the side load port
	task automatic setf(input logic [7:0] f);
		@(posedge ref_clk_i);
		status_flags_register_we_i <= 1'b1;
		status_flags_register_wdata_i <= f;
		@(posedge ref_clk_i);
		status_flags_register_we_i <= 1'b0;
		es = f;
	endtask

	// One issue; checks pc, flags and the number of busy cycles
	task automatic iss(input bsu_op_t o, input logic [2:0] b, input logic [6:0] kk, input logic [7:0] rv,
		input logic [7:0] iov, input logic tw, input logic [15:0] ep, input logic [1:0] ex);
		int n;
		n = 0;
		@(posedge ref_clk_i);
		issue_i <= '{valid:1'b1, op:o, bit_sel:b, io_addr:6'h05, k:kk, reg_val:rv, io_val:iov, next_two_word:tw};
		@(posedge ref_clk_i);
		issue_i.valid <= 1'b0;
		#1;
		cap_rd = rd_data_o;
		cap_rdwe = 8'(rd_we_o);
		cap_io = io_data_o;
		cap_iowe = 8'(io_we_o);
		cap_addr = io_addr_o;
		chk(pc_o, ep);
		chk(16'(status_flags_register_o), 16'(es));
		while (busy_o === 1'b1 && n < 5) begin
			@(posedge ref_clk_i);
			#1;
			n++;
		end
		chk(16'(n), 16'(ex));
		epc = ep;
	endtask

	function automatic logic [15:0] tgt(input logic [6:0] kk);
		return epc + {{9{kk[6]}}, kk} + 16'h0001;
	endfunction

	// Main sequence
	initial begin
		issue_i = '0;
		status_flags_register_we_i = 1'b0;
		status_flags_register_wdata_i = 8'h00;
		srst_i = 1'b1;
		epc = 16'h0000;
		es = 8'h00;
		em = 8'h5A;
		repeat (16) @(posedge ref_clk_i);
		srst_i <= 1'b0;
		@(posedge ref_clk_i);
		#1;
		chk(pc_o, 16'h0000);
		chk(16'({busy_o, status_flags_register_o}), 16'h0000);
		// Skips: hit or miss, one- or two-word follower
		for (int i = 0; i < 16; i++) begin
			v = i[0] ? 8'h10 : 8'hEF;
			hit = v[4] ^ (i / 4 == 0 || i / 4 == 2);
			iss(sk[i / 4], 3'h4, 7'h00, v, v, i[1], epc + (hit ? (i[1] ? 16'h3 : 16'h2) : 16'h1),
				hit ? (i[1] ? 2'h2 : 2'h1) : 2'h0);
		end
		// Every flag index, both polarities, forward and backward offsets
		for (int f = 0; f < 8; f++) begin
			for (int m = 0; m < 4; m++) begin
				s = m[0] ? (8'h01 << f) : ~(8'h01 << f);
				setf(s);
				tk = (s[f] == !m[1]);
				k = f[0] ? 7'h7C : 7'h09;
				iss(m[1] ? BSU_OP_BR_FLAG_LO : BSU_OP_BR_FLAG_HI, 3'(f), k, 8'h00, 8'h00, 1'b0,
					tk ? tgt(k) : epc + 16'h1, {1'b0, tk});
			end
		end
		// Signed branches on every top-bit and wrap combination
		for (int m = 0; m < 8; m++) begin
			setf({4'h0, m[1], m[0], 2'b00});
			tk = ((m[0] ^ m[1]) == m[2]);
			iss(m[2] ? BSU_OP_BR_SIGN_LT : BSU_OP_BR_SIGN_GE, 3'h0, 7'h40, 8'h00, 8'h00, 1'b0,
				tk ? tgt(7'h40) : epc + 16'h1, {1'b0, tk});
		end
		// I/O bit forcing, the byte read back from the far model each time
		for (int b = 0; b < 8; b++) begin
			em[b] = !b[0];
			iss(b[0] ? BSU_OP_IO_ZERO : BSU_OP_IO_ONE, 3'(b), 7'h00, 8'h00, io_rd, 1'b0, epc + 16'h1,
				2'h1);
			chk(16'({cap_iowe, cap_io}), {8'h01, em});
			chk(16'(cap_addr), 16'h0005);
		end
		// Shifts and rotates, carry in both ways, upper flags kept
		for (int j = 0; j < 5; j++) begin
			for (int m = 0; m < 8; m++) begin
				v = vals[m % 4];
				c = m[2];
				setf(8'hF6 | 8'(c));
				r = (j == 0) ? {v[6:0], c} : (j == 1) ? {c, v[7:1]} : (j == 2) ? {v[7], v[7:1]} :
					(j == 3) ? {v[6:0], 1'b0} : {1'b0, v[7:1]};
				co = (j == 0 || j == 3) ? v[7] : v[0];
				es = {es[7:4], r[7] ^ co, r[7], r == 8'h00, co};
				iss(sh[j], 3'h0, 7'h00, v, 8'h00, 1'b0, epc + 16'h1, 2'h0);
				chk(16'({cap_rdwe, cap_rd}), {8'h01, r});
			end
		end
		// Spare bit taken from a register bit, then written into another
		for (int b = 0; b < 8; b++) begin
			es[6] = v[b];
			v = 8'hA5;
			es[6] = v[b];
			iss(BSU_OP_BIT_TO_T, 3'(b), 7'h00, v, 8'h00, 1'b0, epc + 16'h1, 2'h0);
			e = 8'h5A;
			e[b] = es[6];
			iss(BSU_OP_T_TO_BIT, 3'(b), 7'h00, 8'h5A, 8'h00, 1'b0, epc + 16'h1, 2'h0);
			chk(16'({cap_rdwe, cap_rd}), {8'h01, e});
		end
		// Issue left standing through the busy cycle must be ignored
		@(posedge ref_clk_i);
		issue_i <= '{valid:1'b1, op:BSU_OP_SKIP_REG_HI, bit_sel:3'h0, io_addr:6'h05, k:7'h00, reg_val:8'h01,
			io_val:8'h00, next_two_word:1'b0};
		@(posedge ref_clk_i);
		issue_i.op <= BSU_OP_ROT_UP;
		@(posedge ref_clk_i);
		issue_i.valid <= 1'b0;
		#1;
		chk(pc_o, epc + 16'h0002);
		chk(16'({rd_we_o, busy_o, status_flags_register_o}), 16'(es));
		epc = epc + 16'h0002;
		report_and_stop();
	end
endmodule // tb_top
